// >>> design/adc_sync_sleep_regif.sv
// Converter register interface with domain synchronization and standby control
`timescale 1ns/10ps
`include "adc_sync_defs.svh"

module adc_sync_sleep_regif #(
  parameter int SYNC_CYCLES    = `SYNC_CYC,
  parameter int STARTUP_CYCLES = `STARTUP_CYC
) (
  input  wire logic                    MCLK,
  input  wire logic                    RST_N,
  input  wire logic [7:0]              PADDR,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [31:0]             PWDATA,
  input  wire logic [3:0]              PSTRB,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    PROT_ON,
  input  wire logic                    SLEEP_STDBY,
  input  wire logic                    EVT_START,
  input  wire logic                    EVT_FLUSH,
  input  wire logic                    RES_READY,
  input  wire logic                    OVERRUN_EV,
  input  wire logic                    WIN_MATCH,
  input  wire logic [15:0]             RESULT_IN,
  output adc_sync_pkg::core_cfg_t      CORE_CFG,
  output adc_sync_pkg::aux_cfg_t       AUX_CFG,
  output logic                         CONV_ENABLE,
  output logic                         CONV_RUN,
  output logic                         ANALOG_ON,
  output logic                         CONV_START,
  output logic                         CONV_FLUSH,
  output logic                         IRQ,
  output logic                         WAKE_REQ
);
  import adc_sync_pkg::*;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [31:0] regs_r [0:63];
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        soft_reset_bit_r;
  logic        en_r;
  logic        rstby_r;
  logic [3:0]  inten_r;
  logic [3:0]  flag_r;
  logic [3:0]  flag_nxt;
  logic [3:0]  sync_cnt_r;
  logic        core_en_r;
  core_cfg_t   core_r;
  logic        slp1_r;
  logic        slp2_r;
  logic        slp3_r;
  logic        sleep_r;
  pwr_state_t  pw_r;
  logic [15:0] warm_cnt_r;
  logic        run_r;
  logic        ana_r;
  logic        start_r;
  logic        flush_r;
  logic        irq_r;
  logic        wake_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] mask_of(input logic [5:0] ix);
    case (ix)
      `IX_REF:   mask_of = `M_REF;
      `IX_AVG:   mask_of = `M_AVG;
      `IX_SAMP:  mask_of = `M_SAMP;
      `IX_CTL_B: mask_of = `M_CTL_B;
      `IX_WIN:   mask_of = `M_WIN;
      `IX_TRIG:  mask_of = `M_TRIG;
      `IX_INSEL: mask_of = `M_INSEL;
      `IX_EVT:   mask_of = `M_EVT;
      `IX_WLO:   mask_of = `M_W16;
      `IX_WHI:   mask_of = `M_W16;
      `IX_GAIN:  mask_of = `M_COR;
      `IX_OFFS:  mask_of = `M_COR;
      `IX_CAL:   mask_of = `M_CAL;
      `IX_DBG:   mask_of = `M_DBG;
      default:   mask_of = 32'h00000000;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  wire [5:0]  idx      = PADDR[7:2];
  wire [31:0] wmask    = mask_of(idx);
  wire        hit_ca   = (idx == `IX_CTL_A);
  wire        hit_iclr = (idx == `IX_IEN_CLR);
  wire        hit_iset = (idx == `IX_IEN_SET);
  wire        hit_flag = (idx == `IX_IFLAG);
  wire        hit_stat = (idx == `IX_STAT);
  wire        hit_res  = (idx == `IX_RES);
  wire        special  = hit_ca | hit_iclr | hit_iset | hit_flag | hit_stat | hit_res;
  wire        mapped   = special | (wmask != 32'h00000000);
  wire        access   = PSEL & PENABLE;
  wire        busy     = (sync_cnt_r != 4'h0);
  wire        sync_done = (sync_cnt_r == 4'h1);
  // Status and result are read-only, flags stay clearable so a handler can always ack
  wire        wp_block = PROT_ON & ~hit_flag & ~hit_stat & ~hit_res;
  wire        ep_block = (idx == `IX_CAL) & en_r;
  wire        wr_syncd = (hit_ca & PSTRB[0]) | (idx == `IX_CTL_B)
                       | (idx == `IX_TRIG) | (idx == `IX_WIN) | (idx == `IX_INSEL)
                       | (idx == `IX_WLO) | (idx == `IX_WHI);
  wire        rd_syncd = (idx == `IX_TRIG) | (idx == `IX_INSEL);
  wire        blocked  = wp_block | ep_block;
  wire        sync_op  = PWRITE ? (wr_syncd & ~blocked) : rd_syncd;
  wire        stall    = sync_op & busy;
  wire        go       = access & ~pready_r & ~stall;
  wire        commit   = access & pready_r;
  wire        wr_ok    = commit & PWRITE & mapped & ~blocked;
  wire        sync_go  = commit & sync_op & mapped;
  wire        ca_wr    = wr_ok & hit_ca & PSTRB[0];
  wire        soft_reset_bit_wr = ca_wr & PWDATA[`CA_SOFT_RESET_BIT];
  wire        soft_reset_bit_do = sync_done & soft_reset_bit_r;
  wire        upd_core = sync_done & ~soft_reset_bit_r;

  // Of the read-synchronized registers, input select answers with the converter-side copy; trigger reads the bus-side register
  wire [31:0] rd_val =
      hit_ca   ? {29'h0, rstby_r, en_r, soft_reset_bit_r} :
      hit_iclr ? {28'h0, inten_r} :
      hit_iset ? {28'h0, inten_r} :
      hit_flag ? {28'h0, flag_r} :
      hit_stat ? {24'h0, busy, 7'h00} :
      hit_res  ? {16'h0, RESULT_IN} :
      (idx == `IX_INSEL) ? core_r.in_sel :
      regs_r[idx];

  // --------------------------------------------------------------------
  // APB answer: ready one cycle after the access phase starts unless stalled
  // --------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= go;
      pslverr_r <= go & ~mapped;
      prdata_r  <= (go & ~PWRITE & mapped) ? rd_val : 32'h00000000;
    end
  end

  // --------------------------------------------------------------------
  // Plain registers, one per index
  // --------------------------------------------------------------------
  for (genvar i = 0; i < 64; i++) begin : g_reg
    localparam logic [5:0] IX = 6'(i);
    wire hit = wr_ok & (idx == IX) & (mask_of(IX) != 32'h00000000);
    always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
        regs_r[i] <= `RST_VAL;
      end else if (soft_reset_bit_do && IX != `IX_DBG) begin
        regs_r[i] <= `RST_VAL;
      end else if (sync_done && IX == `IX_TRIG) begin
        regs_r[i] <= `RST_VAL;
      end else if (hit) begin
        regs_r[i] <= merge(regs_r[i], PWDATA, PSTRB) & mask_of(IX);
      end
    end
  end

  // --------------------------------------------------------------------
  // Control A and the crossing tracker
  // --------------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_reset_bit_r <= 1'b0;
      en_r    <= 1'b0;
      rstby_r <= 1'b0;
    end else if (soft_reset_bit_do) begin
      soft_reset_bit_r <= 1'b0;
      en_r    <= 1'b0;
      rstby_r <= 1'b0;
    end else if (soft_reset_bit_wr) begin
      soft_reset_bit_r <= 1'b1;
    end else if (ca_wr) begin
      en_r    <= PWDATA[`CA_EN];
      rstby_r <= PWDATA[`CA_RSTBY];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_cnt_r <= 4'h0;
    end else if (sync_go) begin
      sync_cnt_r <= 4'(SYNC_CYCLES);
    end else if (busy) begin
      sync_cnt_r <= sync_cnt_r - 4'h1;
    end
  end

  // Converter-side copies change only when a crossing lands
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      core_r    <= '0;
      core_en_r <= 1'b0;
    end else if (soft_reset_bit_do) begin
      core_r    <= '0;
      core_en_r <= 1'b0;
    end else if (upd_core) begin
      core_en_r       <= en_r;
      core_r.ctl_b    <= regs_r[`IX_CTL_B][15:0];
      core_r.win_mode <= regs_r[`IX_WIN][2:0];
      core_r.in_sel   <= regs_r[`IX_INSEL];
      core_r.win_lo   <= regs_r[`IX_WLO][15:0];
      core_r.win_hi   <= regs_r[`IX_WHI][15:0];
    end
  end

  // --------------------------------------------------------------------
  // Interrupt enable and flags
  // --------------------------------------------------------------------
  wire [3:0] flag_set = {sync_done, WIN_MATCH, OVERRUN_EV, RES_READY};
  wire [3:0] flag_clr = (wr_ok & hit_flag & PSTRB[0]) ? PWDATA[3:0] : 4'h0;

  // A new event in the clearing cycle survives the clear
  assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      inten_r <= 4'h0;
      flag_r  <= 4'h0;
    end else if (soft_reset_bit_do) begin
      inten_r <= 4'h0;
      flag_r  <= 4'(1 << `FL_SYNC);
    end else begin
      flag_r <= flag_nxt;
      if (wr_ok && hit_iset && PSTRB[0]) begin
        inten_r <= inten_r | PWDATA[3:0];
      end else if (wr_ok && hit_iclr && PSTRB[0]) begin
        inten_r <= inten_r & ~PWDATA[3:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Standby sleep
  // --------------------------------------------------------------------
  // Sleep request is from the power manager, so it is filtered through three stages
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      slp1_r  <= 1'b0;
      slp2_r  <= 1'b0;
      slp3_r  <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      slp1_r <= SLEEP_STDBY;
      slp2_r <= slp1_r;
      slp3_r <= slp2_r;
      if (slp2_r == slp3_r) begin
        sleep_r <= slp3_r;
      end
    end
  end

  wire halt_req = sleep_r & ~rstby_r;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pw_r       <= PW_ACTIVE;
      warm_cnt_r <= 16'h0000;
    end else begin
      case (pw_r)
        PW_ACTIVE: begin
          if (halt_req) begin
            pw_r <= PW_HALT;
          end
        end
        PW_HALT: begin
          if (!halt_req) begin
            pw_r       <= PW_WARM;
            warm_cnt_r <= 16'(STARTUP_CYCLES);
          end
        end
        PW_WARM: begin
          if (halt_req) begin
            pw_r <= PW_HALT;
          end else if (warm_cnt_r <= 16'h0001) begin
            pw_r <= PW_ACTIVE;
          end else begin
            warm_cnt_r <= warm_cnt_r - 16'h0001;
          end
        end
        default: begin
          pw_r <= PW_ACTIVE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Converter controls
  // --------------------------------------------------------------------
  // Keep-running leaves the state machine active, so run continues in sleep
  wire run_ok   = core_en_r & (pw_r == PW_ACTIVE) & ~halt_req;
  wire [7:0] ev = regs_r[`IX_EVT][7:0];
  wire [31:0] trg = regs_r[`IX_TRIG];
  wire sw_ok    = upd_core & ~sleep_r;
  wire start_nx = run_ok & ((EVT_START & ev[`EV_STARTEI]) | (sw_ok & trg[`TRIG_START]));
  wire flush_nx = run_ok & ((EVT_FLUSH & ev[`EV_FLUSHEI]) | (sw_ok & trg[`TRIG_FLUSH]));
  wire irq_any  = |(flag_r & inten_r);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      run_r   <= 1'b0;
      ana_r   <= 1'b0;
      start_r <= 1'b0;
      flush_r <= 1'b0;
      irq_r   <= 1'b0;
      wake_r  <= 1'b0;
    end else begin
      run_r   <= run_ok;
      ana_r   <= core_en_r & (pw_r != PW_HALT) & ~halt_req;
      start_r <= start_nx;
      flush_r <= flush_nx;
      irq_r   <= irq_any;
      wake_r  <= sleep_r & rstby_r & irq_any;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign PRDATA           = prdata_r;
  assign PREADY           = pready_r;
  assign PSLVERR          = pslverr_r;
  assign CORE_CFG         = core_r;
  assign CONV_ENABLE      = core_en_r;
  assign CONV_RUN         = run_r;
  assign ANALOG_ON        = ana_r;
  assign CONV_START       = start_r;
  assign CONV_FLUSH       = flush_r;
  assign IRQ              = irq_r;
  assign WAKE_REQ         = wake_r;
  assign AUX_CFG.ref_ctl  = regs_r[`IX_REF][7:0];
  assign AUX_CFG.avg_ctl  = regs_r[`IX_AVG][6:0];
  assign AUX_CFG.samp_ctl = regs_r[`IX_SAMP][5:0];
  assign AUX_CFG.evt_ctl  = regs_r[`IX_EVT][7:0];
  assign AUX_CFG.gain_cor = regs_r[`IX_GAIN][11:0];
  assign AUX_CFG.offs_cor = regs_r[`IX_OFFS][11:0];
  assign AUX_CFG.cal      = regs_r[`IX_CAL][10:0];
  assign AUX_CFG.dbg_run  = regs_r[`IX_DBG][0];

endmodule

// >>> design/adc_sync_defs.svh
// Register indices, field masks and timing counts for the converter register interface
`ifndef ADC_SYNC_DEFS_SVH
`define ADC_SYNC_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IX_CTL_A    6'h00
`define IX_REF      6'h01
`define IX_AVG      6'h02
`define IX_SAMP     6'h03
`define IX_CTL_B    6'h04
`define IX_WIN      6'h08
`define IX_TRIG     6'h0c
`define IX_INSEL    6'h10
`define IX_EVT      6'h14
`define IX_IEN_CLR  6'h16
`define IX_IEN_SET  6'h17
`define IX_IFLAG    6'h18
`define IX_STAT     6'h19
`define IX_RES      6'h1a
`define IX_WLO      6'h1c
`define IX_WHI      6'h20
`define IX_GAIN     6'h24
`define IX_OFFS     6'h26
`define IX_CAL      6'h28
`define IX_DBG      6'h2a

// ----------------------------------------------------------------------
// Writable bit masks and reset value
// ----------------------------------------------------------------------
`define M_REF       32'h0000008f
`define M_AVG       32'h0000007f
`define M_SAMP      32'h0000003f
`define M_CTL_B     32'h0000073f
`define M_WIN       32'h00000007
`define M_TRIG      32'h00000003
`define M_INSEL     32'h0fff1f1f
`define M_EVT       32'h00000033
`define M_W16       32'h0000ffff
`define M_COR       32'h00000fff
`define M_CAL       32'h000007ff
`define M_DBG       32'h00000001
`define RST_VAL     32'h00000000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CA_SOFT_RESET_BIT    0
`define CA_EN       1
`define CA_RSTBY    2
`define TRIG_FLUSH  0
`define TRIG_START  1
`define EV_STARTEI  0
`define EV_FLUSHEI  1
`define FL_SYNC     3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_NS      100
`define SYNC_CYC    4
`define STARTUP_NS  20000
`define STARTUP_CYC ((`STARTUP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> design/adc_sync_pkg.sv
// Types shared by the converter register interface
package adc_sync_pkg;

  typedef enum logic [2:0] {
    PW_ACTIVE = 3'b001,
    PW_HALT   = 3'b010,
    PW_WARM   = 3'b100
  } pwr_state_t;

  typedef struct packed {
    logic [15:0] ctl_b;
    logic [2:0]  win_mode;
    logic [31:0] in_sel;
    logic [15:0] win_lo;
    logic [15:0] win_hi;
  } core_cfg_t;

  typedef struct packed {
    logic [7:0]  ref_ctl;
    logic [6:0]  avg_ctl;
    logic [5:0]  samp_ctl;
    logic [7:0]  evt_ctl;
    logic [11:0] gain_cor;
    logic [11:0] offs_cor;
    logic [10:0] cal;
    logic        dbg_run;
  } aux_cfg_t;

endpackage

// >>> tb/adc_sync_sleep_regif_chk.sv
// Port-level assertions for the converter register interface
`timescale 1ns/10ps
module adc_sync_sleep_regif_chk #(
  parameter int SYNC_CYCLES = 4
) (
  input wire logic                    MCLK,
  input wire logic                    RST_N,
  input wire logic [7:0]              PADDR,
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic [31:0]             PWDATA,
  input wire logic [3:0]              PSTRB,
  input wire logic [31:0]             PRDATA,
  input wire logic                    PREADY,
  input wire logic                    PSLVERR,
  input wire logic                    PROT_ON,
  input wire logic                    EVT_START,
  input wire adc_sync_pkg::core_cfg_t CORE_CFG,
  input wire adc_sync_pkg::aux_cfg_t  AUX_CFG,
  input wire logic                    CONV_ENABLE,
  input wire logic                    CONV_RUN,
  input wire logic                    ANALOG_ON,
  input wire logic                    CONV_START
);
  import adc_sync_pkg::*;
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire         hit_b = PADDR[7:2] == 6'h04 && PSTRB == 4'hf && !PROT_ON;
  logic [15:0] exp_b_r;
  sequence wr_commit;
    PSEL && PENABLE && PREADY && PWRITE;
  endsequence
  sequence acc_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  // Expected converter copy of control B, only writable bits survive
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      exp_b_r <= 16'h0000;
    end else if (PSEL && PENABLE && PREADY && PWRITE && hit_b) begin
      exp_b_r <= PWDATA[15:0] & 16'h073f;
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  chk_ready_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside an access phase");
  chk_ready_bound: assert property (acc_wait |-> ##[1:16] PREADY)
    else $error("stall not ended in time");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h00000000)
    else $error("read data driven outside ready");
  chk_slverr_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  chk_ctlb_sync: assert property (wr_commit ##0 hit_b |-> ##[1:10] CORE_CFG.ctl_b == exp_b_r)
    else $error("control B copy not updated");
  chk_prot_hold: assert property (wr_commit ##0 (PROT_ON && PADDR[7:2] == 6'h04)
    |=> $stable(CORE_CFG) [*8])
    else $error("protected write changed config");
  chk_event_start: assert property (EVT_START && AUX_CFG.evt_ctl[0] && CONV_RUN |=> CONV_START)
    else $error("event did not start conversion");
  chk_analog_run: assert property (!ANALOG_ON ##1 !ANALOG_ON |-> !CONV_RUN)
    else $error("running with analog off");
  chk_run_enable: assert property (!CONV_ENABLE ##1 !CONV_ENABLE |-> !CONV_RUN)
    else $error("running while disabled");
endmodule

bind adc_sync_sleep_regif adc_sync_sleep_regif_chk #(.SYNC_CYCLES(SYNC_CYCLES))
  i_adc_sync_sleep_regif_chk (
  .MCLK(MCLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PROT_ON(PROT_ON), .EVT_START(EVT_START), .CORE_CFG(CORE_CFG),
  .AUX_CFG(AUX_CFG), .CONV_ENABLE(CONV_ENABLE), .CONV_RUN(CONV_RUN),
  .ANALOG_ON(ANALOG_ON), .CONV_START(CONV_START));

// >>> tb/apb_host_model.sv
// APB master model standing in for the processor on the register bus
`timescale 1ns/10ps
module apb_host_model (
  input  wire logic        MCLK,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  output logic      [7:0]  PADDR,
  output logic             PSEL,
  output logic             PENABLE,
  output logic             PWRITE,
  output logic      [31:0] PWDATA,
  output logic      [3:0]  PSTRB
);
  initial begin
    PADDR = 8'h00;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PWDATA = 32'h00000000;
    PSTRB = 4'h0;
  end
  // ----------------------------------------------------------------------
  // One transfer; held however long the slave stalls, n counts its edges
  // ----------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e,
                      output int n);
    n = 1;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Released data lines show the inverse, never a stale match
    PWDATA <= ~d;
  endtask
endmodule

// >>> tb/test_adc_sync_sleep_regif.sv
// Self-checking testbench for the converter register interface
`timescale 1ns/10ps
`include "adc_sync_defs.svh"
module test_adc_sync_sleep_regif;
  import adc_sync_pkg::*;
  localparam int STUP = 20;
  localparam logic [5:0] MAP [19] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h14, 6'h16,
    6'h17, 6'h18, 6'h19, 6'h1c, 6'h20, 6'h24, 6'h26, 6'h28, 6'h2a, 6'h0c, 6'h10};
  logic        mclk, rst_n, prot_on, sleep_stdby, err;
  logic [4:0]  pulse_src;
  logic [15:0] result_in;
  logic [31:0] q;
  wire  [7:0]  paddr;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [31:0] pwdata, prdata;
  wire  [3:0]  pstrb;
  core_cfg_t   core_cfg;
  aux_cfg_t    aux_cfg;
  logic        conv_enable, conv_run, analog_on, conv_start, conv_flush, irq, wake_req;
  int          n_fail, cmp_count, tmo, hits, ncyc;
  adc_sync_sleep_regif #(.SYNC_CYCLES(4), .STARTUP_CYCLES(STUP)) i_adc_sync_sleep_regif (
    .MCLK(mclk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PROT_ON(prot_on), .SLEEP_STDBY(sleep_stdby),
    .EVT_START(pulse_src[0]), .EVT_FLUSH(pulse_src[1]), .RES_READY(pulse_src[2]),
    .OVERRUN_EV(pulse_src[3]), .WIN_MATCH(pulse_src[4]), .RESULT_IN(result_in),
    .CORE_CFG(core_cfg), .AUX_CFG(aux_cfg), .CONV_ENABLE(conv_enable), .CONV_RUN(conv_run),
    .ANALOG_ON(analog_on), .CONV_START(conv_start), .CONV_FLUSH(conv_flush), .IRQ(irq),
    .WAKE_REQ(wake_req));
  apb_host_model i_apb_host_model (
    .MCLK(mclk), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PSTRB(pstrb));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ix, input logic [31:0] d, input logic [3:0] s);
    i_apb_host_model.xfer(1'b1, {ix, 2'b00}, d, s, q, err, ncyc);
  endtask
  task automatic rd(input logic [5:0] ix, input logic [31:0] exp);
    i_apb_host_model.xfer(1'b0, {ix, 2'b00}, 32'h0, 4'h0, q, err, ncyc);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    pulse_src <= 5'h01 << k;
    @(posedge mclk);
    pulse_src <= 5'h00;
  endtask
  // Start pulses last one cycle, so every cycle of the window is looked at
  task automatic see_start(input int n);
    hits = 0;
    repeat (n) begin
      @(posedge mclk);
      hits += (conv_start === 1'b1);
    end
  endtask
  task automatic stop_test;
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    foreach (MAP[i]) rd(MAP[i], 32'h0);
    rd(`IX_RES, 32'h0abc);
    rd(6'h05, 32'h0);
    chk(err, 1'b1);
    $display("reset map done");
  endtask
  task automatic t_sync;
    wr(`IX_CTL_B, 32'h0000ffff, 4'hf);
    chk(ncyc, 3);
    rd(`IX_STAT, 32'h80);
    cyc(8);
    rd(`IX_STAT, 32'h0);
    chk(core_cfg.ctl_b, 16'h073f);
    wr(`IX_IFLAG, 32'h0, 4'hf);
    rd(`IX_IFLAG, 32'h8);
    wr(`IX_IFLAG, 32'h8, 4'hf);
    rd(`IX_IFLAG, 32'h0);
    $display("sync write done");
  endtask
  task automatic t_stall;
    wr(`IX_WIN, 32'h5, 4'hf);
    wr(`IX_WLO, 32'h1234, 4'hf);
    chk(ncyc > 3, 1'b1);
    wr(`IX_WHI, 32'habcd, 4'hf);
    cyc(8);
    chk(core_cfg.win_mode, 3'h5);
    chk({core_cfg.win_lo, core_cfg.win_hi}, 32'h1234abcd);
    $display("stall done");
  endtask
  task automatic t_bytes;
    wr(`IX_INSEL, 32'hffffffff, 4'hf);
    wr(`IX_INSEL, 32'h0, 4'h4);
    wr(`IX_INSEL, 32'h00000a05, 4'h3);
    wr(`IX_CTL_B, 32'h00000200, 4'h2);
    cyc(8);
    rd(`IX_INSEL, 32'h0f000a05);
    rd(`IX_CTL_B, 32'h023f);
    $display("byte lanes done");
  endtask
  task automatic t_prot;
    prot_on <= 1'b1;
    wr(`IX_REF, 32'h8f, 4'hf);
    wr(`IX_CTL_B, 32'h0, 4'hf);
    prot_on <= 1'b0;
    rd(`IX_REF, 32'h0);
    rd(`IX_CTL_B, 32'h023f);
    wr(`IX_REF, 32'hff, 4'hf);
    rd(`IX_REF, 32'h8f);
    chk(aux_cfg.ref_ctl, 8'h8f);
    $display("protection done");
  endtask
  task automatic t_enprot;
    wr(`IX_CTL_A, 32'h2, 4'hf);
    cyc(8);
    chk(conv_enable, 1'b1);
    wr(`IX_CAL, 32'h7ff, 4'hf);
    rd(`IX_CAL, 32'h0);
    wr(`IX_CTL_A, 32'h0, 4'hf);
    cyc(8);
    wr(`IX_CAL, 32'h7ff, 4'hf);
    rd(`IX_CAL, 32'h7ff);
    chk(aux_cfg.cal, 11'h7ff);
    $display("enable protection done");
  endtask
  task automatic t_halt;
    wr(`IX_EVT, 32'h3, 4'hf);
    wr(`IX_CTL_A, 32'h2, 4'hf);
    cyc(STUP + 10);
    pulse(0);
    see_start(3);
    chk(hits, 1);
    pulse(1);
    cyc(1);
    chk(conv_flush, 1'b1);
    wr(`IX_TRIG, 32'h2, 4'hf);
    see_start(12);
    chk(hits, 1);
    sleep_stdby <= 1'b1;
    cyc(8);
    chk({conv_run, analog_on}, 2'b00);
    rd(`IX_CTL_B, 32'h023f);
    sleep_stdby <= 1'b0;
    cyc(8);
    chk(conv_run, 1'b0);
    cyc(STUP + 8);
    chk(conv_run, 1'b1);
    $display("halted standby done");
  endtask
  task automatic t_keep;
    wr(`IX_CTL_A, 32'h6, 4'hf);
    sleep_stdby <= 1'b1;
    cyc(8);
    chk({conv_run, analog_on}, 2'b11);
    wr(`IX_TRIG, 32'h2, 4'hf);
    see_start(12);
    chk(hits, 0);
    pulse(0);
    see_start(3);
    chk(hits, 1);
    for (int k = 2; k < 5; k++) begin
      wr(`IX_IEN_SET, 32'h1 << (k - 2), 4'hf);
      pulse(k);
      cyc(3);
      chk({irq, wake_req}, 2'b11);
      wr(`IX_IEN_CLR, 32'hf, 4'hf);
      wr(`IX_IFLAG, 32'hf, 4'hf);
    end
    pulse(2);
    cyc(3);
    chk({irq, wake_req}, 2'b00);
    sleep_stdby <= 1'b0;
    $display("keep running done");
  endtask
  task automatic t_soft_reset_bit;
    wr(`IX_DBG, 32'h1, 4'hf);
    wr(`IX_CTL_A, 32'h0, 4'hf);
    cyc(8);
    wr(`IX_CTL_A, 32'h7, 4'hf);
    rd(`IX_CTL_A, 32'h1);
    cyc(10);
    chk(conv_enable, 1'b0);
    rd(`IX_CTL_B, 32'h0);
    rd(`IX_IFLAG, 32'h8);
    rd(`IX_DBG, 32'h1);
    $display("soft reset done");
  endtask
  // ----------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    tmo = 0;
    forever begin
      @(posedge mclk);
      tmo++;
      if (tmo == 5000) begin
        n_fail++;
        stop_test;
      end
    end
  end
  initial begin
    rst_n = 1'b0;
    prot_on = 1'b0;
    sleep_stdby = 1'b0;
    pulse_src = 5'h00;
    result_in = 16'h0abc;
    n_fail = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_sync;
    t_stall;
    t_bytes;
    t_prot;
    t_enprot;
    t_halt;
    t_keep;
    t_soft_reset_bit;
    stop_test;
  end
endmodule
